// [dscr_pkg.sv]
// Purpose : Shared constants and carriers for the debug status/control low half
// Assumes : Single 20 MHz core clock, asynchronous active-high reset
// Notes   : Offsets are byte addresses on the memory-mapped debug port
package dscr_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [11:0] STATUS_OFFSET     = 12'h0088;
   localparam logic [11:0] RUN_CTRL_OFFSET   = 12'h0090;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int BIT_HALTED       = 0;
   localparam int BIT_RESTARTED    = 1;
   localparam int ENTRY_LSB        = 2;
   localparam int ENTRY_MSB        = 5;
   localparam int BIT_STICKY_SYNC  = 6;
   localparam int BIT_STICKY_ASYNC = 7;
   localparam int BIT_STICKY_UNDEF = 8;
   localparam int BIT_RSVD9        = 9;
   localparam int BIT_RSVD10       = 10;
   localparam int BIT_INT_DISABLE  = 11;
   localparam int BIT_HALT_EN      = 14;
   localparam int BIT_MON_EN       = 15;
   localparam int BIT_CLR_STICKY   = 2;

   // ****************************************************************
   // Entry method codes
   // ****************************************************************
   localparam logic [3:0] ENTRY_HALT_REQ  = 4'h0;
   localparam logic [3:0] ENTRY_BREAK     = 4'h1;
   localparam logic [3:0] ENTRY_UNSUPP    = 4'h2;
   localparam logic [3:0] ENTRY_BREAKPOINT_INSTRUCTION_INSN = 4'h3;
   localparam logic [3:0] ENTRY_EXT_HALT  = 4'h4;
   localparam logic [3:0] ENTRY_VEC_CATCH = 4'h5;
   localparam logic [3:0] ENTRY_WATCH     = 4'hA;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [3:0] ENTRY_RESET     = ENTRY_HALT_REQ;
   localparam logic       HALTED_RESET    = 1'b0;
   localparam logic       RESTARTED_RESET = 1'b1;

   // Channel modes of the external data path
   typedef enum logic [1:0] {
      MODE_NONBLOCK = 2'b00,
      MODE_STALL    = 2'b01,
      MODE_FAST     = 2'b10
   } channel_mode_t;

   // Cause lines from the core, one-hot pulses
   typedef struct packed {
      logic breakpoint;
      logic bkptInsn;
      logic extHalt;
      logic vecCatch;
      logic watchpoint;
      logic haltReq;
   } entry_cause_t;

   // Memory-mapped port request
   typedef struct packed {
      logic        sel;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } dbg_req_t;

endpackage : dscr_pkg

// [sticky_flag.sv]
// Purpose : One hardware-set, software-cleared sticky flag
// Assumes : Set and clear are single-cycle on sys_clk
// Notes   : Set wins over clear so a late event is never lost
module sticky_flag (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic setFlag,
   input  wire logic clearFlag,
   output logic      flag
);

   typedef struct packed {
      logic flag;
   } state_t;

   state_t state;
   state_t next_state;

   // Set has priority over clear
   always_comb begin
      next_state = state;
      if (clearFlag) begin
         next_state.flag = 1'b0;
      end
      if (setFlag) begin
         next_state.flag = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign flag = state.flag;

   a_set_wins : assert property (@(posedge sys_clk) disable iff (rst)
      setFlag |=> flag) else $error("sticky flag not set after event");

endmodule : sticky_flag

// [entry_encoder.sv]
// Purpose : Turn debug-entry cause pulses into an entry method code
// Assumes : At most one cause at a time; priority picks if several
// Notes   : Only listed codes can leave this block
module entry_encoder
   import dscr_pkg::*;
(
   input  entry_cause_t cause,
   output logic         anyCause,
   output logic [3:0]   code
);

   // Fixed priority; the unsupported code has no path to the output
   always_comb begin
      anyCause = |cause;
      code     = ENTRY_HALT_REQ;
      if (cause.breakpoint) begin
         code = ENTRY_BREAK;
      end else if (cause.bkptInsn) begin
         code = ENTRY_BREAKPOINT_INSTRUCTION_INSN;
      end else if (cause.watchpoint) begin
         code = ENTRY_WATCH;
      end else if (cause.vecCatch) begin
         code = ENTRY_VEC_CATCH;
      end else if (cause.extHalt) begin
         code = ENTRY_EXT_HALT;
      end
   end

endmodule : entry_encoder

// [debug_status_control.sv]
// Purpose : Low half of the debug status and control register with its side effects
// Assumes : Debug port request arrives on sys_clk; pins pass a 2-FF synchroniser
// Notes   : Upper control bits 15:14 are held here only for their gating role
//
// Overview of operation
// [R01] - Set interrupt-disable bit 11 masks normal and fast interrupts; resets to 0.
// [R02] - Interrupt-disable is ignored when bits 15:14 are 00 or debug enable low.
// [R03] - Reserved bit 9 reads zero; writers keep it zero.
// [R04] - Bit 8 sticks on undefined-instruction exception in debug state.
// [R05] - Bit 7 sticks on asynchronous abort in debug state.
// [R06] - Bit 6 sticks on synchronous data abort in debug state.
// [R07] - Writing 1 to run control bit 2 clears the three sticky flags.
// [R08] - Sync-abort flag set blocks instruction transfer issue and writes.
// [R09] - Sync-abort flag in Fast mode ignores transmit reads and receive writes.
// [R10] - Entry method field 5:2 is read/write, encoding listed causes, reset 0000.
// [R11] - Code 0010 and other reserved codes are never generated.
// [R12] - Each debug entry loads the entry method with its cause code.
// [R13] - Restarted bit 1 reads 0 while leaving debug, 1 after; resets 1.
// [R14] - Halted bit 0 reads 1 in debug state, 0 in normal; resets 0.
// [R15] - Status bits track live state; core reset forces 10.
// [R16] - Debugger polls halted and restarted bits for entry and exit.
// [R17] - Internal coprocessor view of the register is read-only.
// [R18] - External view is read/write at offset 0x88.
// [R19] - Bits 14/15 enable halting/monitor modes, reset 0, read 0 if disabled.
// [R20] - Fast mode: receive write or transmit read issues the transfer instruction.
// [R21] - Bit 10 reads zero and ignores writes.
module debug_status_control
   import dscr_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          coreDebugResetN,
   input  wire logic          invasiveDebugEnable,
   input  wire dbg_req_t      dbgReq,
   output logic [31:0]        dbgRdata,
   output logic [31:0]        internalView,
   input  wire entry_cause_t  entryCause,
   input  wire logic          inDebugState,
   input  wire logic          leavingDebug,
   input  wire logic          undefInDebug,
   input  wire logic          asyncAbortInDebug,
   input  wire logic          syncAbortInDebug,
   input  wire channel_mode_t channelMode,
   input  wire logic          irqIn,
   input  wire logic          fiqIn,
   output logic               irqMasked,
   output logic               fiqMasked,
   input  wire logic          itrWrite,
   input  wire logic          rxWrite,
   input  wire logic          txRead,
   output logic               itrAccept,
   output logic               rxAccept,
   output logic               txAccept,
   output logic               issueInstr
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic       syncA;        // First stage of pin synchroniser
      logic       syncB;
      logic       coreRstA;
      logic       coreRstB;
      logic       intDisable;
      logic       haltEn;
      logic       monEn;
      logic [3:0] entryMethod;
      logic       halted;
      logic       restarted;
      logic       prevDebug;
      logic [31:0] rdata;
   } state_t;

   state_t state;
   state_t next_state;

   logic stickyUndef;
   logic stickyAsync;
   logic stickySync;
   logic clearSticky;
   logic anyEntry;
   logic [3:0] entryCode;
   logic dbgEnable;
   logic coreReset;
   logic statusWrite;
   logic [31:0] regView;
   logic intMaskActive;

   assign dbgEnable = state.syncB;
   assign coreReset = ~state.coreRstB;

   // ****************************************************************
   // Sticky exception flags
   // ****************************************************************
   // Clear strobe from the run control register write
   assign clearSticky = dbgReq.sel && dbgReq.write && (dbgReq.addr == RUN_CTRL_OFFSET)
                        && dbgReq.wdata[BIT_CLR_STICKY];          // [R07]

   sticky_flag undefFlag (                                       // [R04]
      .sys_clk   (sys_clk),
      .rst       (rst),
      .setFlag   (undefInDebug && state.halted),
      .clearFlag (clearSticky),
      .flag      (stickyUndef)
   );

   sticky_flag asyncFlag (                                       // [R05]
      .sys_clk   (sys_clk),
      .rst       (rst),
      .setFlag   (asyncAbortInDebug && state.halted),
      .clearFlag (clearSticky),
      .flag      (stickyAsync)
   );

   sticky_flag syncFlag (                                        // [R06]
      .sys_clk   (sys_clk),
      .rst       (rst),
      .setFlag   (syncAbortInDebug && state.halted),
      .clearFlag (clearSticky),
      .flag      (stickySync)
   );

   entry_encoder encoder (                                       // [R11]
      .cause    (entryCause),
      .anyCause (anyEntry),
      .code     (entryCode)
   );

   // ****************************************************************
   // Register view
   // ****************************************************************
   // Bits 10 and 9 are hard zero; mode enables read 0 while debug disabled
   always_comb begin
      regView                  = '0;
      regView[BIT_MON_EN]      = state.monEn && dbgEnable;       // [R19]
      regView[BIT_HALT_EN]     = state.haltEn && dbgEnable;      // [R19]
      regView[BIT_INT_DISABLE] = state.intDisable;
      regView[BIT_RSVD10]      = 1'b0;                           // [R21]
      regView[BIT_RSVD9]       = 1'b0;                           // [R03]
      regView[BIT_STICKY_UNDEF] = stickyUndef;
      regView[BIT_STICKY_ASYNC] = stickyAsync;
      regView[BIT_STICKY_SYNC]  = stickySync;
      regView[ENTRY_MSB:ENTRY_LSB] = state.entryMethod;
      regView[BIT_RESTARTED]   = state.restarted;
      regView[BIT_HALTED]      = state.halted;
   end

   // Internal view is driven only, never written from the core side
   assign internalView = regView;                                // [R17]

   assign statusWrite = dbgReq.sel && dbgReq.write && (dbgReq.addr == STATUS_OFFSET); // [R18]

   // ****************************************************************
   // Interrupt masking
   // ****************************************************************
   // Mask only counts while some debug mode is on and debug is enabled
   assign intMaskActive = state.intDisable && dbgEnable
                          && (state.haltEn || state.monEn);       // [R02]
   assign irqMasked = irqIn && !intMaskActive;                   // [R01]
   assign fiqMasked = fiqIn && !intMaskActive;                   // [R01]

   // ****************************************************************
   // Transfer gating
   // ****************************************************************
   // The abort flag stops issue so a faulting sequence cannot run on
   assign itrAccept  = itrWrite && !stickySync;                  // [R08]
   assign rxAccept   = rxWrite && !(stickySync && channelMode == MODE_FAST); // [R09]
   assign txAccept   = txRead && !(stickySync && channelMode == MODE_FAST);  // [R09]
   always_comb begin
      if (channelMode == MODE_FAST) begin
         issueInstr = (rxAccept || txAccept) && !stickySync;     // [R20]
      end else begin
         issueInstr = itrAccept;                                 // [R08]
      end
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_state          = state;
      next_state.syncA    = invasiveDebugEnable;
      next_state.syncB    = state.syncA;
      next_state.coreRstA = coreDebugResetN;
      next_state.coreRstB = state.coreRstA;
      next_state.prevDebug = inDebugState;
      if (statusWrite) begin
         next_state.intDisable  = dbgReq.wdata[BIT_INT_DISABLE];
         next_state.haltEn      = dbgReq.wdata[BIT_HALT_EN];
         next_state.monEn       = dbgReq.wdata[BIT_MON_EN];
         next_state.entryMethod = dbgReq.wdata[ENTRY_MSB:ENTRY_LSB]; // [R10]
      end
      // Hardware cause wins over a simultaneous software write
      if (anyEntry) begin
         next_state.entryMethod = entryCode;                     // [R12]
      end
      // Live status; restarted drops while leaving, rises once out
      next_state.halted = inDebugState;                          // [R14]
      if (leavingDebug) begin
         next_state.restarted = 1'b0;                            // [R13]
      end else if (!inDebugState) begin
         next_state.restarted = 1'b1;                            // [R13]
      end
      if (coreReset) begin
         next_state.halted    = HALTED_RESET;                    // [R15]
         next_state.restarted = RESTARTED_RESET;                 // [R15]
      end
      // Read data registered; unmapped offsets read zero
      next_state.rdata = (dbgReq.sel && !dbgReq.write && dbgReq.addr == STATUS_OFFSET)
                         ? regView : 32'h0000_0000;              // [R16]
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state             <= '0;
         state.entryMethod <= ENTRY_RESET;
         state.restarted   <= RESTARTED_RESET;
         state.halted      <= HALTED_RESET;
         state.coreRstA    <= 1'b1;
         state.coreRstB    <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign dbgRdata = state.rdata;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_irq_masked : assert property (@(posedge sys_clk) disable iff (rst) // [R01]
      (state.intDisable && dbgEnable && state.haltEn) |-> !irqMasked && !fiqMasked)
      else $error("interrupt passed while disabled");
   a_mask_ignored : assert property (@(posedge sys_clk) disable iff (rst) // [R02]
      (!dbgEnable || (!state.haltEn && !state.monEn)) |-> irqMasked == irqIn)
      else $error("interrupt masked while disable ignored");
   a_rsvd_zero : assert property (@(posedge sys_clk) disable iff (rst) // [R03]
      !regView[BIT_RSVD9] && !regView[BIT_RSVD10])
      else $error("reserved bit reads one");
   a_sticky_clear : assert property (@(posedge sys_clk) disable iff (rst) // [R07]
      (clearSticky && !undefInDebug && !asyncAbortInDebug && !syncAbortInDebug)
      |=> !stickyUndef && !stickyAsync && !stickySync)
      else $error("sticky flags not cleared");
   a_itr_blocked : assert property (@(posedge sys_clk) disable iff (rst) // [R08]
      stickySync |-> !itrAccept && !issueInstr)
      else $error("instruction issued after sync abort");
   a_fast_blocked : assert property (@(posedge sys_clk) disable iff (rst) // [R09]
      (stickySync && channelMode == MODE_FAST) |-> !rxAccept && !txAccept)
      else $error("fast channel access accepted after abort");
   a_entry_load : assert property (@(posedge sys_clk) disable iff (rst) // [R12]
      anyEntry |=> state.entryMethod == $past(entryCode))
      else $error("entry method not loaded");
   a_entry_legal : assert property (@(posedge sys_clk) disable iff (rst) // [R11]
      anyEntry |=> state.entryMethod != ENTRY_UNSUPP)
      else $error("unsupported entry code generated");
   a_halt_track : assert property (@(posedge sys_clk) disable iff (rst) // [R14]
      (inDebugState && !coreReset) |=> state.halted)
      else $error("halted bit not tracking");
   a_core_reset : assert property (@(posedge sys_clk) disable iff (rst) // [R15]
      coreReset |=> regView[1:0] == 2'b10)
      else $error("core reset did not force status");
   a_fast_issue : assert property (@(posedge sys_clk) disable iff (rst) // [R20]
      (channelMode == MODE_FAST && rxWrite && !stickySync) |-> issueInstr)
      else $error("fast mode did not issue");
   a_mon_mask : assert property (@(posedge sys_clk) disable iff (rst) // [R01]
      (state.intDisable && dbgEnable && state.monEn) |-> !irqMasked && !fiqMasked)
      else $error("interrupt passed under monitor mode");
   a_fiq_ignored : assert property (@(posedge sys_clk) disable iff (rst) // [R02]
      (!dbgEnable || (!state.haltEn && !state.monEn)) |-> fiqMasked == fiqIn)
      else $error("fast interrupt masked while disable ignored");
   a_undef_set : assert property (@(posedge sys_clk) disable iff (rst) // [R04]
      (undefInDebug && state.halted) |=> stickyUndef)
      else $error("undefined flag not set");
   a_async_set : assert property (@(posedge sys_clk) disable iff (rst) // [R05]
      (asyncAbortInDebug && state.halted) |=> stickyAsync)
      else $error("async abort flag not set");
   a_sync_set : assert property (@(posedge sys_clk) disable iff (rst) // [R06]
      (syncAbortInDebug && state.halted) |=> stickySync)
      else $error("sync abort flag not set");
   a_field_write : assert property (@(posedge sys_clk) disable iff (rst) // [R10]
      (statusWrite && !anyEntry)
      |=> state.entryMethod == $past(dbgReq.wdata[ENTRY_MSB:ENTRY_LSB]))
      else $error("entry method write lost");
   a_restart_drop : assert property (@(posedge sys_clk) disable iff (rst) // [R13]
      (leavingDebug && !coreReset) |=> !state.restarted)
      else $error("restarted bit high while leaving");
   a_restart_rise : assert property (@(posedge sys_clk) disable iff (rst) // [R13]
      (!inDebugState && !leavingDebug) |=> state.restarted)
      else $error("restarted bit low after leaving");
   a_halt_clear : assert property (@(posedge sys_clk) disable iff (rst) // [R14]
      !inDebugState |=> !state.halted)
      else $error("halted bit high in normal state");
   a_mode_hidden : assert property (@(posedge sys_clk) disable iff (rst) // [R19]
      !dbgEnable |-> !regView[BIT_HALT_EN] && !regView[BIT_MON_EN])
      else $error("mode bits visible while debug disabled");
   a_read_data : assert property (@(posedge sys_clk) disable iff (rst) // [R18]
      (dbgReq.sel && !dbgReq.write && dbgReq.addr == STATUS_OFFSET)
      |=> dbgRdata == $past(regView))
      else $error("status read returned wrong data");
   a_stall_issue : assert property (@(posedge sys_clk) disable iff (rst) // [R08]
      (channelMode != MODE_FAST) |-> issueInstr == itrAccept)
      else $error("issue not tied to transfer write");
   a_tx_issue : assert property (@(posedge sys_clk) disable iff (rst) // [R20]
      (channelMode == MODE_FAST && txRead && !stickySync) |-> issueInstr)
      else $error("fast transmit read did not issue");

endmodule : debug_status_control

// [dscr_debugger.sv]
// Purpose : Debugger model driving the memory-mapped debug port
// Assumes : One access per call, whole 32-bit words
// Notes   : Idle fields show inverted values so a stale request never looks valid
module dscr_debugger
   import dscr_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic [31:0] dbgRdata,
   output dbg_req_t         dbgReq
);
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************************************
   // Port access
   // ****************************************************************
   initial dbgReq = '0;

   // Request stands for the taking edge only; read data is sampled after it
   task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                         output logic [31:0] rd);
      logic [31:0] wd;
      wd = d & ~32'h0000_0200;   // Reserved bit always written as zero
      @(posedge sys_clk);
      dbgReq <= '{1'b1, wr, a, wd};
      @(posedge sys_clk);
      dbgReq <= '{1'b0, ~wr, ~a, ~wd};
      #1 rd = dbgRdata;
   endtask : access

   // Writing 1 to run control bit 2 wipes the sticky flags
   task automatic clear_sticky();
      logic [31:0] rd;
      access(1'b1, RUN_CTRL_OFFSET, 32'h0000_0004, rd);
   endtask : clear_sticky

   // Poll a status bit, bounded so a dead core cannot hang us
   task automatic poll(input int idx, input logic val, output logic ok);
      logic [31:0] rd;
      ok = 1'b0;
      for (int n = 0; n < 20 && !ok; n++) begin
         access(1'b0, STATUS_OFFSET, 32'h0000_0000, rd);
         ok = (rd[idx] === val);
      end
   endtask : poll
endmodule : dscr_debugger

// [tb_debug_status_control.sv]
// Purpose : Self-checking bench for the debug status/control low half
// Assumes : Pins pass a 2-FF synchroniser, so waits of 4 cycles cover them
// Notes   : Random register data from a fixed-seed xorshift
module tb_debug_status_control
   import dscr_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   logic          sys_clk, rst, coreDebugResetN, invasiveDebugEnable;
   dbg_req_t      dbgReq;
   logic [31:0]   dbgRdata, internalView, rd, w, seed;
   entry_cause_t  entryCause;
   logic          inDebugState, leavingDebug, undefInDebug, asyncAbortInDebug;
   logic          syncAbortInDebug, irqIn, fiqIn, irqMasked, fiqMasked, ok;
   channel_mode_t channelMode;
   logic          itrWrite, rxWrite, txRead, itrAccept, rxAccept, txAccept, issueInstr;
   int            err_count, num_checks;
   logic [3:0]    codeOf [6] = '{ENTRY_HALT_REQ, ENTRY_WATCH, ENTRY_VEC_CATCH,
                                  ENTRY_EXT_HALT, ENTRY_BREAKPOINT_INSTRUCTION_INSN, ENTRY_BREAK};

   debug_status_control i_debug_status_control (.sys_clk(sys_clk), .rst(rst),
      .coreDebugResetN(coreDebugResetN), .invasiveDebugEnable(invasiveDebugEnable),
      .dbgReq(dbgReq), .dbgRdata(dbgRdata), .internalView(internalView),
      .entryCause(entryCause), .inDebugState(inDebugState), .leavingDebug(leavingDebug),
      .undefInDebug(undefInDebug), .asyncAbortInDebug(asyncAbortInDebug),
      .syncAbortInDebug(syncAbortInDebug), .channelMode(channelMode), .irqIn(irqIn),
      .fiqIn(fiqIn), .irqMasked(irqMasked), .fiqMasked(fiqMasked), .itrWrite(itrWrite),
      .rxWrite(rxWrite), .txRead(txRead), .itrAccept(itrAccept), .rxAccept(rxAccept),
      .txAccept(txAccept), .issueInstr(issueInstr));

   dscr_debugger i_dscr_debugger (.sys_clk(sys_clk), .dbgRdata(dbgRdata), .dbgReq(dbgReq));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Interrupt passes unless bit 11 is set, a mode bit is set and debug is enabled
   function automatic logic exp_pass(logic in, logic [31:0] v, logic en);
      return in & !(v[11] && en && (v[15:14] != 2'b00));
   endfunction : exp_pass

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic end_of_test();
      $display("checks %0d, errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   // Whole run is well under 3000 cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_count++;
      end_of_test();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      seed = 32'h0001_60F5;
      {rst, coreDebugResetN, invasiveDebugEnable} = 3'b111;
      entryCause = '0;
      {inDebugState, leavingDebug, undefInDebug, asyncAbortInDebug} = 4'h0;
      {syncAbortInDebug, irqIn, fiqIn, itrWrite, rxWrite, txRead} = 6'h00;
      channelMode = MODE_FAST;
      tick(2);
      rst <= 1'b0;
      tick(4);
      i_dscr_debugger.access(1'b0, STATUS_OFFSET, 32'h0000_0000, rd);
      check("reset status", rd, 32'h0000_0002);
      check("internal view", internalView, 32'h0000_0002);
      // Random writes: only the writable fields come back, bits 10 and 9 read zero
      for (int k = 0; k < 6; k++) begin
         w = rnd();
         i_dscr_debugger.access(1'b1, STATUS_OFFSET, w, rd);
         i_dscr_debugger.access(1'b0, STATUS_OFFSET, 32'h0000_0000, rd);
         check("writable fields", rd & 32'h0000_CE3C, w & 32'h0000_C83C);
         irqIn <= w[16];
         fiqIn <= w[17];
         tick(1);
         check("irq gate", irqMasked, exp_pass(w[16], w, 1'b1));
         check("fiq gate", fiqMasked, exp_pass(w[17], w, 1'b1));
      end
      // Debug enable low overrides the mask and hides the mode bits
      i_dscr_debugger.access(1'b1, STATUS_OFFSET, 32'h0000_C800, rd);
      {irqIn, fiqIn, invasiveDebugEnable} <= 3'b110;
      tick(4);
      check("irq disabled gate", irqMasked, 1'b1);
      i_dscr_debugger.access(1'b0, STATUS_OFFSET, 32'h0000_0000, rd);
      check("mode bits hidden", rd[15:14], 2'b00);
      invasiveDebugEnable <= 1'b1;
      tick(4);
      check("fiq masked", fiqMasked, 1'b0);
      i_dscr_debugger.access(1'b1, STATUS_OFFSET, 32'h0000_0000, rd);
      i_dscr_debugger.clear_sticky();
      // Enter debug state and walk every entry cause
      inDebugState <= 1'b1;
      i_dscr_debugger.poll(BIT_HALTED, 1'b1, ok);
      check("halted seen", ok, 1'b1);
      for (int i = 5; i >= 0; i--) begin
         entryCause <= entry_cause_t'(6'h01 << i);
         tick(1);
         entryCause <= '0;
         tick(2);
         check("entry code", internalView[5:2], codeOf[i]);
      end
      // Sticky flags and the transfers they block
      undefInDebug <= 1'b1;
      tick(1);
      {undefInDebug, asyncAbortInDebug} <= 2'b01;
      tick(1);
      {asyncAbortInDebug, syncAbortInDebug} <= 2'b01;
      tick(1);
      syncAbortInDebug <= 1'b0;
      tick(2);
      check("sticky set", internalView[8:6], 3'b111);
      {itrWrite, rxWrite, txRead} <= 3'b111;
      tick(1);
      check("blocked accepts", {itrAccept, rxAccept, txAccept, issueInstr}, 4'h0);
      {itrWrite, rxWrite, txRead} <= 3'b000;
      i_dscr_debugger.clear_sticky();
      tick(1);
      check("sticky cleared", internalView[8:6], 3'b000);
      rxWrite <= 1'b1;
      tick(1);
      check("fast issue", {rxAccept, issueInstr}, 2'b11);
      {rxWrite, txRead} <= 2'b01;
      tick(1);
      check("fast tx issue", {txAccept, issueInstr}, 2'b11);
      {txRead, itrWrite} <= 2'b01;
      channelMode <= MODE_STALL;
      tick(1);
      check("itr accepted", {itrAccept, issueInstr}, 2'b11);
      itrWrite <= 1'b0;
      // Leave debug state
      {inDebugState, leavingDebug} <= 2'b01;
      tick(3);
      check("leaving status", internalView[1:0], 2'b00);
      leavingDebug <= 1'b0;
      i_dscr_debugger.poll(BIT_RESTARTED, 1'b1, ok);
      check("restart seen", {ok, internalView[1:0]}, 3'b110);
      // Core reset while halted forces the status pair back
      inDebugState <= 1'b1;
      tick(3);
      coreDebugResetN <= 1'b0;
      tick(4);
      check("core reset status", internalView[1:0], 2'b10);
      coreDebugResetN <= 1'b1;
      tick(4);
      end_of_test();
   end
endmodule : tb_debug_status_control
